//--- pkg/opo_pkg.sv
/*
   Register map, field layout, reset values and types for the eight-pin output
   port with timer and oscillator clock outputs.
   Assumes a 32-bit AHB-Lite register bus and one system clock.
*/
package opo_pkg;

   // Printed offsets are not word aligned: they are register indices
   localparam logic [15:0] IDX_CLOCK_OUT_CONTROL    = 16'hFF06;
   localparam logic [15:0] IDX_LOW_GROUP_FLOAT      = 16'hFF30;
   localparam logic [15:0] IDX_LOW_GROUP_DATA       = 16'hFF31;
   localparam logic [15:0] IDX_HIGH_GROUP_FLOAT     = 16'hFF32;
   localparam logic [15:0] IDX_HIGH_GROUP_DATA      = 16'hFF33;
   localparam logic [15:0] IDX_TIMER_OUT_PRESCALER  = 16'hFFC1;
   // Own register: slow oscillator rate selection
   localparam logic [15:0] IDX_SLOW_RATE            = 16'hFFC2;

   localparam logic [17:0] ADDR_SHIFT_ZERO = 18'h00000;

   // Field positions
   localparam int unsigned FOFQ_LO_BIT    = 0;
   localparam int unsigned FOFQ_HI_BIT    = 1;
   localparam int unsigned OSC_EN_BIT     = 3;
   localparam int unsigned PSC0_BIT       = 0;
   localparam int unsigned PSC1_BIT       = 1;
   localparam int unsigned TIMER_CLOCK_OUT_EN_BIT    = 2;
   localparam int unsigned TIMER_OUT_CHANNEL_SEL_BIT      = 3;

   // Reset values
   localparam logic [3:0] DATA_RESET  = 4'hF;
   localparam logic [3:0] FLOAT_RESET = 4'h0;
   localparam logic [3:0] CTRL_RESET  = 4'h0;
   localparam logic [1:0] RATE_RESET  = 2'h0;

   // Writable bit masks; other positions read zero
   localparam logic [3:0] MASK_CLOCK_OUT = 4'hB;
   localparam logic [3:0] MASK_HIGH_FLT  = 4'h1;
   localparam logic [3:0] MASK_FULL      = 4'hF;
   localparam logic [1:0] MASK_RATE      = 2'h3;

   // Frequency select codes
   localparam logic [1:0] FQ_FAST   = 2'h3;
   localparam logic [1:0] FQ_SLOW   = 2'h2;
   localparam logic [1:0] FQ_DIV_LO = 2'h1;

   // Slow oscillator rates: 0 = 32.768 kHz, 1 = 76.8 kHz, 2 = 153.6 kHz
   localparam logic [1:0] RATE_32K  = 2'h0;
   localparam logic [1:0] RATE_76K  = 2'h1;

   // Divider tap index k selects slow/2^k; index 0 selects slow/256
   localparam logic [2:0] TAP_8   = 3'h3;
   localparam logic [2:0] TAP_16  = 3'h4;
   localparam logic [2:0] TAP_32  = 3'h5;
   localparam logic [2:0] TAP_64  = 3'h6;
   localparam logic [2:0] TAP_128 = 3'h7;
   localparam int unsigned DIV_W  = 8;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   typedef struct packed
   {
      logic       osc_en;
      logic [1:0] freq_sel;
      logic       timer_en;
      logic       chan_sel;
      logic [1:0] psc_sel;
      logic [1:0] slow_rate;
   } opo_ctrl_t;

   typedef struct packed
   {
      logic [7:0] level;
      logic [7:0] drive_en;
   } opo_pins_t;

endpackage

//--- src/opo_port.sv
/*
   Eight-pin output port with timer clock on pin two and oscillator clock on
   pin three, registers reached over AHB-Lite.
   Assumes all clock sources arrive asynchronously to mclk and are slower than
   half of mclk; they are sampled, so pin clocks carry mclk-quantised edges.
*/
// Added by the designer: the AHB-Lite slave port.
// Overview of operation
// - Reset: data ones, float zeros, pins high
// - Float bit one floats pin, else drive
// - DC output follows data; reads return stored
// - Data zero forces clock pin low
// - Timer clock on pin two when enabled
// - Channel select picks timer one or zero
// - Oscillator clock on pin three when enabled
// - Codes: fast, slow, slow/8, slow/64 at 32k
// - 76.8k/153.6k divide by 16/32, 128/256
// - Float bit overrides selected clock output
// - Four low float bits, one shared high
// - Two prescaler source bits: fast or slow
// - Unused bits read zero, ignore writes
`timescale 1ns/100ps
module opo_port
(
   // System
   input  wire logic        mclk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Clock sources
   input  wire logic        timer0_clock,
   input  wire logic        timer1_clock,
   input  wire logic        slow_osc_clock,
   input  wire logic        fast_osc_clock,
   // Prescaler source selects to the timer
   output logic             prescaler0_source_sel,
   output logic             prescaler1_source_sel,
   // Pins
   output logic      [7:0]  pin_out,
   output logic      [7:0]  pin_oe
);

   // Register state
   logic [3:0] low_group_data,  next_low_group_data;
   logic [3:0] low_group_float, next_low_group_float;
   logic [3:0] high_group_data, next_high_group_data;
   logic       high_group_float, next_high_group_float;
   opo_pkg::opo_ctrl_t ctrl, next_ctrl;
   // Bus data-phase state
   logic        wr_pend,  next_wr_pend;
   logic [15:0] wr_idx,   next_wr_idx;
   logic [31:0] rdata,    next_rdata;

   function automatic logic [15:0] word_index(input logic [31:0] a);
      word_index = a[17:2];
   endfunction

   function automatic logic [3:0] read_reg(input logic [15:0] idx,
                                           input logic [3:0] ld, input logic [3:0] lf,
                                           input logic [3:0] hd, input logic hf,
                                           input opo_pkg::opo_ctrl_t c);
      unique case (idx)
         opo_pkg::IDX_CLOCK_OUT_CONTROL:   read_reg = {c.osc_en, 1'b0, c.freq_sel};
         opo_pkg::IDX_LOW_GROUP_FLOAT:     read_reg = lf;
         opo_pkg::IDX_LOW_GROUP_DATA:      read_reg = ld;
         opo_pkg::IDX_HIGH_GROUP_FLOAT:    read_reg = {3'h0, hf};
         opo_pkg::IDX_HIGH_GROUP_DATA:     read_reg = hd;
         opo_pkg::IDX_TIMER_OUT_PRESCALER: read_reg = {c.chan_sel, c.timer_en, c.psc_sel};
         opo_pkg::IDX_SLOW_RATE:           read_reg = {2'h0, c.slow_rate};
         default:                          read_reg = 4'h0;
      endcase
   endfunction

   logic addr_phase;
   assign addr_phase = hsel && hready && htrans == opo_pkg::HTRANS_NONSEQ;

   always_comb
   begin
      next_low_group_data   = low_group_data;
      next_low_group_float  = low_group_float;
      next_high_group_data  = high_group_data;
      next_high_group_float = high_group_float;
      next_ctrl             = ctrl;
      next_wr_pend          = addr_phase && hwrite;
      next_wr_idx           = word_index(haddr);
      next_rdata            = 32'h0000_0000;
      if (addr_phase && !hwrite)
      begin
         next_rdata[3:0] = read_reg(word_index(haddr), low_group_data, low_group_float,
                                    high_group_data, high_group_float, ctrl);
      end
      if (wr_pend)
      begin
         unique case (wr_idx)
            opo_pkg::IDX_CLOCK_OUT_CONTROL:
            begin
               next_ctrl.osc_en   = hwdata[opo_pkg::OSC_EN_BIT];
               next_ctrl.freq_sel = {hwdata[opo_pkg::FOFQ_HI_BIT], hwdata[opo_pkg::FOFQ_LO_BIT]};
            end
            opo_pkg::IDX_LOW_GROUP_FLOAT:  next_low_group_float  = hwdata[3:0];
            opo_pkg::IDX_LOW_GROUP_DATA:   next_low_group_data   = hwdata[3:0];
            opo_pkg::IDX_HIGH_GROUP_FLOAT: next_high_group_float = hwdata[0];
            opo_pkg::IDX_HIGH_GROUP_DATA:  next_high_group_data  = hwdata[3:0];
            opo_pkg::IDX_TIMER_OUT_PRESCALER:
            begin
               next_ctrl.chan_sel = hwdata[opo_pkg::TIMER_OUT_CHANNEL_SEL_BIT];
               next_ctrl.timer_en = hwdata[opo_pkg::TIMER_CLOCK_OUT_EN_BIT];
               next_ctrl.psc_sel  = {hwdata[opo_pkg::PSC1_BIT], hwdata[opo_pkg::PSC0_BIT]};
            end
            opo_pkg::IDX_SLOW_RATE:        next_ctrl.slow_rate = hwdata[1:0] & opo_pkg::MASK_RATE;
            default:                       next_ctrl = ctrl;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         low_group_data   <= opo_pkg::DATA_RESET;
         high_group_data  <= opo_pkg::DATA_RESET;
         low_group_float  <= opo_pkg::FLOAT_RESET;
         high_group_float <= 1'b0;
         ctrl             <= '0;
         wr_pend          <= 1'b0;
         wr_idx           <= 16'h0000;
         rdata            <= 32'h0000_0000;
      end
      else
      begin
         low_group_data   <= next_low_group_data;
         high_group_data  <= next_high_group_data;
         low_group_float  <= next_low_group_float;
         high_group_float <= next_high_group_float;
         ctrl             <= next_ctrl;
         wr_pend          <= next_wr_pend;
         wr_idx           <= next_wr_idx;
         rdata            <= next_rdata;
      end
   end

   assign hrdata    = rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign prescaler0_source_sel = ctrl.psc_sel[0];
   assign prescaler1_source_sel = ctrl.psc_sel[1];

   // Two-flop synchronisers for all asynchronous clock sources
   logic [3:0] src_meta, src_sync, src_prev;
   logic [3:0] next_src_prev;
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         src_meta <= 4'h0;
         src_sync <= 4'h0;
         src_prev <= 4'h0;
      end
      else
      begin
         src_meta <= {fast_osc_clock, slow_osc_clock, timer1_clock, timer0_clock};
         src_sync <= src_meta;
         src_prev <= next_src_prev;
      end
   end
   assign next_src_prev = src_sync;

   logic t0_s, t1_s, slow_s, fast_s, slow_rise;
   assign {fast_s, slow_s, t1_s, t0_s} = src_sync;
   assign slow_rise = slow_s && !src_prev[2];

   // Slow clock divider; each bit k toggles at slow/2^(k+1)
   logic [opo_pkg::DIV_W-1:0] div_cnt, next_div_cnt;
   assign next_div_cnt = slow_rise ? div_cnt + 8'h01 : div_cnt;

   function automatic logic [2:0] div_tap(input logic [1:0] rate, input logic lo);
      if (rate == opo_pkg::RATE_32K)
         div_tap = lo ? opo_pkg::TAP_8  : opo_pkg::TAP_64;
      else if (rate == opo_pkg::RATE_76K)
         div_tap = lo ? opo_pkg::TAP_16 : opo_pkg::TAP_128;
      else
         div_tap = lo ? opo_pkg::TAP_32 : 3'h0;
   endfunction

   // Source selection for the oscillator output
   logic osc_src, tmr_src;
   logic [2:0] tap;
   always_comb
   begin
      tap = div_tap(ctrl.slow_rate, ctrl.freq_sel == opo_pkg::FQ_DIV_LO);
      unique case (ctrl.freq_sel)
         opo_pkg::FQ_FAST: osc_src = fast_s;
         opo_pkg::FQ_SLOW: osc_src = slow_s;
         default:
         begin
            // slow/256 uses the top counter bit
            if (tap == 3'h0)
               osc_src = div_cnt[opo_pkg::DIV_W-1];
            else
               osc_src = div_cnt[tap - 3'h1];
         end
      endcase
      tmr_src = ctrl.chan_sel ? t1_s : t0_s;
   end

   // Enables change only while the selected source is high: an off pin idles high,
   // so switching then never cuts a low or high phase short
   logic osc_gate, next_osc_gate, tmr_gate, next_tmr_gate;
   assign next_osc_gate = osc_src ? ctrl.osc_en : osc_gate;
   assign next_tmr_gate = tmr_src ? ctrl.timer_en : tmr_gate;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         div_cnt  <= 8'h00;
         osc_gate <= 1'b0;
         tmr_gate <= 1'b0;
      end
      else
      begin
         div_cnt  <= next_div_cnt;
         osc_gate <= next_osc_gate;
         tmr_gate <= next_tmr_gate;
      end
   end

   // Pin levels; gated clock is high when off so the pin idles high
   opo_pkg::opo_pins_t pins, next_pins;
   always_comb
   begin
      next_pins.level    = {high_group_data, low_group_data};
      next_pins.level[2] = low_group_data[2] && (tmr_gate ? tmr_src : 1'b1);
      next_pins.level[3] = low_group_data[3] && (osc_gate ? osc_src : 1'b1);
      next_pins.drive_en = ~{{4{high_group_float}}, low_group_float};
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         pins.level    <= 8'hFF;
         pins.drive_en <= 8'hFF;
      end
      else
      begin
         pins <= next_pins;
      end
   end

   assign pin_out = pins.level;
   assign pin_oe  = pins.drive_en;

endmodule

//--- test/opo_pin_model.sv
/*
   Far-side model: resolves the eight pin wires and counts rising edges
   on pins two and three. Assumes pin_out and pin_oe come from the port.
*/
`timescale 1ns/100ps
module opo_pin_model
(
   // Port side
   input  wire logic       mclk,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   // Observed wires
   output logic      [7:0] lvl,
   output int              e2,
   output int              e3
);
   logic [7:0] last = 8'h00;
   // No keeper on a floated pin, so it must not look like a held level
   assign lvl = (pin_out & pin_oe) | (~last & ~pin_oe);
   always @(posedge mclk)
   begin
      if (pin_oe[2] && lvl[2] && !last[2]) e2++;
      if (pin_oe[3] && lvl[3] && !last[3]) e3++;
      last <= lvl;
   end
endmodule

//--- test/opo_port_sva.sv
/*
   Checker for the output port: reset state, read data and pin changes.
   Assumes one clock mclk and a synchronous active-high rst.
*/
`timescale 1ns/100ps
module opo_port_sva
(
   // System
   input wire logic        mclk,
   input wire logic        rst,
   // Bus
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   // Sources and outputs
   input wire logic        timer0_clock,
   input wire logic        timer1_clock,
   input wire logic        prescaler0_source_sel,
   input wire logic        prescaler1_source_sel,
   input wire logic [7:0]  pin_out,
   input wire logic [7:0]  pin_oe
);
   logic       ap;
   logic       rd1;
   logic [4:0] wsh;
   logic [7:0] tsh;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   assign ap = hsel && hready && htrans == opo_pkg::HTRANS_NONSEQ;
   // Recent writes and timer activity, the only causes of pin changes outside pin three, which follows the oscillator
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rd1 <= 1'b0;
         wsh <= 5'h00;
         tsh <= 8'h00;
      end
      else
      begin
         rd1 <= ap && !hwrite;
         wsh <= {wsh[3:0], ap && hwrite};
         tsh <= {tsh[6:0], timer0_clock | timer1_clock};
      end
   end
   property p_rst_val;
      $fell(rst) |-> pin_out == 8'hFF && pin_oe == 8'hFF && hrdata == 32'h0;
   endproperty
   a_rst_val: assert property (p_rst_val) else $error("bad state after reset");
   property p_unused;
      hrdata[31:4] == 28'h0;
   endproperty
   a_unused: assert property (p_unused) else $error("unused read bits set");
   property p_rd_only;
      hrdata != 32'h0 |-> rd1;
   endproperty
   a_rd_only: assert property (p_rd_only) else $error("read data outside read");
   property p_group;
      pin_oe[7:4] == 4'h0 || pin_oe[7:4] == 4'hF;
   endproperty
   a_group: assert property (p_group) else $error("high group split");
   property p_dc;
      $changed({pin_out[7:4], pin_out[1:0]}) |-> |wsh;
   endproperty
   a_dc: assert property (p_dc) else $error("dc pin moved unwritten");
   property p_oe;
      $changed(pin_oe) |-> |wsh;
   endproperty
   a_oe: assert property (p_oe) else $error("drive enable moved unwritten");
   property p_psc;
      $changed({prescaler1_source_sel, prescaler0_source_sel}) |-> |wsh;
   endproperty
   a_psc: assert property (p_psc) else $error("prescaler select moved");
   property p_tclk;
      $rose(pin_out[2]) |-> |wsh || |tsh;
   endproperty
   a_tclk: assert property (p_tclk) else $error("pin two rose without cause");
   c_write: cover property (ap && hwrite);
   c_read: cover property (rd1);
   c_tclk: cover property ($rose(pin_out[2]) && !(|wsh));
endmodule

bind opo_port opo_port_sva chk_u
(
   .mclk, .rst, .hsel, .htrans, .hwrite, .hready, .hrdata, .timer0_clock, .timer1_clock,
   .prescaler0_source_sel, .prescaler1_source_sel, .pin_out, .pin_oe
);

//--- test/opo_port_bench.sv
/*
   Bench for opo_port: AHB-Lite master, register model, clock rate counts.
   Assumes the pin model and the checker are compiled before it.
*/
`timescale 1ns/100ps
module opo_port_bench;
   logic        mclk = 0, rst = 1, hsel = 0, hwrite = 0, rdy, p0, p1, resp;
   logic [1:0]  htrans = 0;
   logic [3:0]  src = 0;
   logic [7:0]  pin_out, pin_oe, lvl;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, d;
   logic [15:0] idx_t[8] = '{16'hFF06, 16'hFF30, 16'hFF31, 16'hFF32, 16'hFF33, 16'hFFC1,
                             16'hFFC2, 16'h0123};
   logic [3:0]  msk_t[8] = '{4'hB, 4'hF, 4'hF, 4'h1, 4'hF, 4'hF, 4'h3, 4'h0};
   int          mreg[8] = '{0, 0, 15, 0, 15, 0, 0, 0};
   int          n_errors = 0, n_compared = 0, cyc = 0, sn[4], e2, e3, i;
   always #2 mclk = ~mclk;
   always #20 src[0] = ~src[0];
   always #36 src[1] = ~src[1];
   always #20 src[2] = ~src[2];
   // Fast oscillator runs from time zero, so it is started before it is selected
   always #12 src[3] = ~src[3];
   for (genvar g = 0; g < 4; g++)
      always @(posedge src[g]) sn[g]++;
   opo_port dut_u (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(opo_pkg::HSIZE_WORD),
      .hready(rdy), .hwdata, .hrdata, .hreadyout(rdy), .hresp(resp), .timer0_clock(src[0]),
      .timer1_clock(src[1]), .slow_osc_clock(src[2]), .fast_osc_clock(src[3]),
      .prescaler0_source_sel(p0), .prescaler1_source_sel(p1), .pin_out, .pin_oe);
   opo_pin_model pm_u (.mclk, .pin_out, .pin_oe, .lvl, .e2, .e3);
   task automatic wrap_up();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_errors++;
         wrap_up();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         $display("BAD %s exp %h got %h", nm, exp, got);
         n_errors++;
      end
   endtask
   task automatic bus(input logic w, input int k, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= opo_pkg::HTRANS_NONSEQ;
      haddr <= {14'h0, idx_t[k], 2'h0};
      hwrite <= w;
      do @(posedge mclk); while (rdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk); while (rdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input int k, input logic [31:0] wd);
      mreg[k] = wd & msk_t[k];
      bus(1'b1, k, wd);
   endtask
   task automatic rdchk(input int k);
      bus(1'b0, k, 32'h0);
      chk("register", mreg[k], rd);
      chk("hresp", 32'h0, {31'h0, resp});
   endtask
   task automatic chk_pins();
      logic [7:0] oe;
      oe = {{4{~mreg[3][0]}}, ~mreg[1][3:0]};
      // A clock gate waits for a high phase of its source; timer one is the slowest here
      repeat (24) @(posedge mclk);
      chk("pins", {oe, {mreg[4][3:0], mreg[2][3:0]} & oe}, {pin_oe, lvl & pin_oe});
      chk("prescaler_sel", mreg[5][1:0], {p1, p0});
   endtask
   task automatic measure(input int s, input int dv);
      int se, pe;
      // Settle past one source period so the gate is on before counting starts
      repeat (20 * dv + 30) @(posedge mclk);
      se = sn[s];
      pe = s < 2 ? e2 : e3;
      repeat (40 * dv + 100) @(posedge mclk);
      se = sn[s] - se;
      pe = (s < 2 ? e2 : e3) - pe;
      n_compared++;
      if (pe * dv > se + dv || pe * dv + dv < se)
      begin
         $display("BAD clock_edges exp %0d got %0d", se / dv, pe);
         n_errors++;
      end
   endtask
   initial
   begin
      void'($urandom(32'h5128));
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk("reset_pins", 16'hFFFF, {pin_oe, pin_out});
      for (int k = 0; k < 8; k++) rdchk(k);
      // Clock enables kept off here so every pin shows its DC level
      for (int n = 0; n < 24; n++)
      begin
         i = $urandom_range(7);
         d = $urandom;
         if (i == 0) d[3] = 1'b0;
         if (i == 5) d[2] = 1'b0;
         wr(i, d);
         rdchk(i);
         chk_pins();
      end
      wr(2, 4'hF);
      wr(1, 4'h0);
      wr(3, 4'h0);
      for (int c = 0; c < 2; c++)
      begin
         wr(5, {c[0], 3'h4});
         measure(c, 1);
      end
      wr(2, 4'hB);
      chk_pins();
      wr(2, 4'hF);
      wr(1, 4'h4);
      chk_pins();
      wr(1, 4'h0);
      wr(5, 4'h0);
      chk_pins();
      for (int r = 0; r < 3; r++)
      begin
         wr(6, r);
         for (int q = 0; q < 4; q++)
         begin
            wr(0, 8 + q);
            measure(q == 3 ? 3 : 2, q[1] ? 1 : (q[0] ? 8 : 64) << r);
         end
      end
      wr(2, 4'h7);
      chk_pins();
      // Disable on the fast source so the gate turns off within a few cycles
      wr(0, 4'h3);
      wr(2, 4'hF);
      chk_pins();
      wrap_up();
   end
endmodule
